// ==== design/dsc_ctrl.sv ====
// Purpose: Conversion sequencing, channel and span control and serial readout
//          of a dual 12-bit successive-approximation converter.
// Assumes: All pins are asynchronous to CLK; the serial clock is sampled, not used
//          as a clock, so it must stay well below CLK / 4.
// Notes:   The comparators report whether the held input is at or above the
//          current trial code; OSC_DIV must be at least 4 to cover their sync delay.
// Contract
// - trigger fall holds both stages, starts both
// - busy rises when conversions begin
// - busy falls when both conversions complete; stays high while the result FIFO is full
// - busy fall returns stages to track
// - converters clocked by internal oscillator
// - results read by serial clock after conversion
// - reference select level picks internal reference
// - span code decodes to three ranges
// - pair select latched at busy rise, next
// - pair zero first inputs, one second
// - first inputs selected after power-up
// - results coded in two's complement
// - twelve-bit code, 4096 equal steps
// - two serial lines, one per converter
// - chip select low enables and shifts lines
// - trigger low at end powers down
// - 24 clocks read both results
`timescale 1ns/1ps
module dsc_ctrl #(
  parameter int OSC_DIV  = dsc_pkg::OSC_DIV,
  parameter int WAKE_CYC = dsc_pkg::WAKE_CYC
) (
  input  wire logic                      CLK,
  input  wire logic                      RESETN,
  input  wire logic                      CONVERSION_TRIGGER_N,
  input  wire logic                      CHIP_SELECT_N,
  input  wire logic                      SERIAL_CLOCK,
  input  wire logic                      PAIR_SELECT,
  input  wire logic                      SPAN_SELECT_LO,
  input  wire logic                      SPAN_SELECT_HI,
  input  wire logic                      REFERENCE_SOURCE_SELECT,
  input  wire logic                      COMPARE_A,
  input  wire logic                      COMPARE_B,
  output      logic                      BUSY,
  output      logic                      HOLD,
  output      logic                      INPUT_SELECT,
  output      logic [dsc_pkg::DATA_W-1:0] DAC_CODE_A,
  output      logic [dsc_pkg::DATA_W-1:0] DAC_CODE_B,
  output      logic                      SPAN_BIPOLAR_10V,
  output      logic                      SPAN_BIPOLAR_5V,
  output      logic                      SPAN_UNIPOLAR_10V,
  output      logic                      REF_INTERNAL,
  output      logic                      POWER_DOWN,
  output      logic                      RESULT_LINE_A_O,
  output      logic                      RESULT_LINE_A_OE,
  output      logic                      RESULT_LINE_B_O,
  output      logic                      RESULT_LINE_B_OE
);

  localparam int OSC_W = $clog2(OSC_DIV);
  localparam int DW    = dsc_pkg::DATA_W;
  localparam int LW    = dsc_pkg::LINE_BITS;

  function automatic logic [DW-1:0] sar_step(input logic [DW-1:0] trial,
                                             input logic [3:0]    idx,
                                             input logic          keep);
    logic [DW-1:0] nxt;
    nxt      = trial;
    nxt[idx] = keep;
    if (idx != 4'h0) begin
      nxt[idx - 4'h1] = 1'b1;
    end
    return nxt;
  endfunction : sar_step

  logic [dsc_pkg::SYNC_W-1:0] pin_vec;
  logic [dsc_pkg::SYNC_W-1:0] sync1_ff;
  logic [dsc_pkg::SYNC_W-1:0] sync2_ff;
  logic                       trig_prev_ff;
  logic                       cs_prev_ff;
  logic                       sclk_prev_ff;
  logic                       trig_fall;
  logic                       trig_rise;
  logic                       cs_fall;
  logic                       sclk_fall;
  logic                       cs_low;

  dsc_pkg::dsc_state_t        state_ff;
  logic                       busy_ff;
  logic                       busy_q_ff;
  logic                       hold_ff;
  logic                       pair_ff;
  logic [1:0]                 span_ff;
  logic [OSC_W-1:0]           osc_cnt_ff;
  logic                       osc_tick;
  logic [3:0]                 idx_ff;
  logic [dsc_pkg::WAKE_W-1:0] wake_cnt_ff;
  logic [DW-1:0]              sar_ff [2];
  logic [1:0]                 comp_s;
  logic                       start;
  logic                       stored;

  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic [LW-1:0]              fifo_out_data;
  logic [LW-1:0]              push_data;
  logic [LW-1:0]              last_ff;
  logic [LW-1:0]              shift_a_ff;
  logic [LW-1:0]              shift_b_ff;
  logic [LW-1:0]              load_word;
  logic                       oe_ff;
  logic [4:0]                 bit_cnt_ff;
  logic                       ref_ff;
  logic [2:0]                 span_dec_ff;

  assign pin_vec = {CONVERSION_TRIGGER_N, CHIP_SELECT_N, SERIAL_CLOCK, PAIR_SELECT,
                    SPAN_SELECT_HI, SPAN_SELECT_LO, REFERENCE_SOURCE_SELECT,
                    COMPARE_B, COMPARE_A};

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_ff <= dsc_pkg::SYNC_RST;
      sync2_ff <= dsc_pkg::SYNC_RST;
    end else begin
      sync1_ff <= pin_vec;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      trig_prev_ff <= 1'b1;
      cs_prev_ff   <= 1'b1;
      sclk_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= sync2_ff[dsc_pkg::P_TRIG_N];
      cs_prev_ff   <= sync2_ff[dsc_pkg::P_CS_N];
      sclk_prev_ff <= sync2_ff[dsc_pkg::P_SCLK];
    end
  end

  assign trig_fall = trig_prev_ff && !sync2_ff[dsc_pkg::P_TRIG_N];
  assign trig_rise = !trig_prev_ff && sync2_ff[dsc_pkg::P_TRIG_N];
  assign cs_fall   = cs_prev_ff && !sync2_ff[dsc_pkg::P_CS_N];
  assign sclk_fall = sclk_prev_ff && !sync2_ff[dsc_pkg::P_SCLK];
  assign cs_low    = !sync2_ff[dsc_pkg::P_CS_N];
  assign comp_s    = {sync2_ff[dsc_pkg::P_COMP_B], sync2_ff[dsc_pkg::P_COMP_A]};

  assign start  = (state_ff == dsc_pkg::ST_IDLE) && trig_fall;
  assign stored = (state_ff == dsc_pkg::ST_STORE) && fifo_in_ready;

  assign osc_tick = (state_ff == dsc_pkg::ST_CONVERT) && (osc_cnt_ff == OSC_W'(OSC_DIV - 1));

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      osc_cnt_ff <= '0;
    end else if (start || osc_tick) begin
      osc_cnt_ff <= '0;
    end else if (state_ff == dsc_pkg::ST_CONVERT) begin
      osc_cnt_ff <= osc_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff    <= dsc_pkg::ST_IDLE;
      idx_ff      <= dsc_pkg::IDX_MSB;
      wake_cnt_ff <= '0;
    end else begin
      case (state_ff)
        dsc_pkg::ST_IDLE: begin
          if (start) begin
            state_ff <= dsc_pkg::ST_CONVERT;
            idx_ff   <= dsc_pkg::IDX_MSB;
          end
        end
        dsc_pkg::ST_CONVERT: begin
          if (osc_tick) begin
            idx_ff <= idx_ff - 4'h1;
            if (idx_ff == 4'h0) begin
              state_ff <= dsc_pkg::ST_STORE;
            end
          end
        end
        dsc_pkg::ST_STORE: begin
          if (fifo_in_ready) begin
            state_ff <= sync2_ff[dsc_pkg::P_TRIG_N] ? dsc_pkg::ST_IDLE : dsc_pkg::ST_DOWN;
          end
        end
        dsc_pkg::ST_DOWN: begin
          if (trig_rise) begin
            state_ff    <= dsc_pkg::ST_WAKE;
            wake_cnt_ff <= '0;
          end
        end
        dsc_pkg::ST_WAKE: begin
          if (wake_cnt_ff == dsc_pkg::WAKE_W'(WAKE_CYC - 1)) begin
            state_ff <= dsc_pkg::ST_IDLE;
          end else begin
            wake_cnt_ff <= wake_cnt_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= dsc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      busy_ff   <= 1'b0;
      busy_q_ff <= 1'b0;
    end else begin
      busy_q_ff <= busy_ff;
      if (start) begin
        busy_ff <= 1'b1;
      end else if (stored) begin
        busy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hold_ff <= 1'b0;
    end else if (start) begin
      hold_ff <= 1'b1;
    end else if (busy_q_ff && !busy_ff) begin
      hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pair_ff <= dsc_pkg::PAIR_RST;
      span_ff <= dsc_pkg::SPAN_BIP10;
    end else if (start) begin
      pair_ff <= sync2_ff[dsc_pkg::P_PAIR];
      span_ff <= {sync2_ff[dsc_pkg::P_SPAN_HI], sync2_ff[dsc_pkg::P_SPAN_LO]};
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      span_dec_ff <= 3'h0;
      ref_ff      <= 1'b0;
    end else begin
      span_dec_ff <= {span_ff == dsc_pkg::SPAN_UNI10, span_ff == dsc_pkg::SPAN_BIP5,
                      span_ff == dsc_pkg::SPAN_BIP10};
      ref_ff      <= sync2_ff[dsc_pkg::P_REF];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_sar
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        sar_ff[g] <= dsc_pkg::SAR_RST;
      end else if (start) begin
        sar_ff[g] <= dsc_pkg::SAR_MSB;
      end else if (osc_tick) begin
        sar_ff[g] <= sar_step(sar_ff[g], idx_ff, comp_s[g]);
      end
    end
  end

  // flip sign bit for two's complement
  assign push_data = {~sar_ff[0][DW-1], sar_ff[0][DW-2:0], ~sar_ff[1][DW-1], sar_ff[1][DW-2:0]};

  // results reach the reader only after conversion
  dsc_fifo #(
    .WIDTH (LW),
    .DEPTH (dsc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RESETN),
    .in_valid  (state_ff == dsc_pkg::ST_STORE),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (cs_fall),
    .out_data  (fifo_out_data)
  );

  assign load_word = fifo_out_valid ? fifo_out_data : last_ff;

  // frame opens on chip select fall
  // line b leads with its own result
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      last_ff    <= dsc_pkg::LINE_RST;
      shift_a_ff <= dsc_pkg::LINE_RST;
      shift_b_ff <= dsc_pkg::LINE_RST;
      bit_cnt_ff <= '0;
    end else if (cs_fall) begin
      last_ff    <= load_word;
      shift_a_ff <= load_word;
      shift_b_ff <= {load_word[DW-1:0], load_word[LW-1:DW]};
      bit_cnt_ff <= '0;
    end else if (cs_low && sclk_fall) begin
      shift_a_ff <= {shift_a_ff[LW-2:0], 1'b0};
      shift_b_ff <= {shift_b_ff[LW-2:0], 1'b0};
      if (bit_cnt_ff != 5'(LW)) begin
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= cs_low;
    end
  end

  assign BUSY              = busy_ff;
  assign HOLD              = hold_ff;
  assign INPUT_SELECT      = pair_ff;
  assign DAC_CODE_A        = sar_ff[0];
  assign DAC_CODE_B        = sar_ff[1];
  assign SPAN_BIPOLAR_10V  = span_dec_ff[0];
  assign SPAN_BIPOLAR_5V   = span_dec_ff[1];
  assign SPAN_UNIPOLAR_10V = span_dec_ff[2];
  assign REF_INTERNAL      = ref_ff;
  assign POWER_DOWN        = (state_ff == dsc_pkg::ST_DOWN) || (state_ff == dsc_pkg::ST_WAKE);
  assign RESULT_LINE_A_O   = shift_a_ff[LW-1];
  assign RESULT_LINE_B_O   = shift_b_ff[LW-1];
  assign RESULT_LINE_A_OE  = oe_ff;
  assign RESULT_LINE_B_OE  = oe_ff;

  a_start_hold: assert property (@(posedge CLK) disable iff (!RESETN)
    start |=> hold_ff && busy_ff && (sar_ff[0] == dsc_pkg::SAR_MSB)
      && (sar_ff[1] == dsc_pkg::SAR_MSB))
    else $error("trigger fall did not hold and start both converters");

  a_busy_rise: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(busy_ff) |-> $past(start))
    else $error("busy rose without a conversion start");

  a_busy_fall: assert property (@(posedge CLK) disable iff (!RESETN)
    $fell(busy_ff) |-> $past(state_ff == dsc_pkg::ST_STORE) && $past(fifo_in_ready))
    else $error("busy fell before results were stored");

  a_track_after: assert property (@(posedge CLK) disable iff (!RESETN)
    $fell(busy_ff) ##1 !start |=> !hold_ff)
    else $error("stages did not return to track after busy fell");

  a_osc_step: assert property (@(posedge CLK) disable iff (!RESETN)
    $past(state_ff == dsc_pkg::ST_CONVERT) && !$stable(idx_ff) |-> $past(osc_tick))
    else $error("converter stepped without an oscillator tick");

  a_span_decode: assert property (@(posedge CLK) disable iff (!RESETN)
    (span_ff == 2'h3) |=> (span_dec_ff == 3'h0))
    else $error("undefined span code selected a range");

  a_pair_latch: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(busy_ff) |-> pair_ff == $past(sync2_ff[dsc_pkg::P_PAIR]))
    else $error("pair select not latched at busy rise");

  a_twos_code: assert property (@(posedge CLK) disable iff (!RESETN)
    stored |-> push_data[LW-1] == !sar_ff[0][DW-1] && push_data[DW-1] == !sar_ff[1][DW-1])
    else $error("result sign bit not in two's complement");

  a_line_enable: assert property (@(posedge CLK) disable iff (!RESETN)
    cs_fall |=> RESULT_LINE_A_OE && RESULT_LINE_B_OE
      && (RESULT_LINE_A_O == $past(load_word[LW-1])))
    else $error("lines not enabled with first bit at chip select fall");

  a_power_down: assert property (@(posedge CLK) disable iff (!RESETN)
    stored && !sync2_ff[dsc_pkg::P_TRIG_N] |=> POWER_DOWN && !busy_ff)
    else $error("trigger low at conversion end did not power down");

  a_no_restart: assert property (@(posedge CLK) disable iff (!RESETN)
    busy_ff && trig_fall && !stored |=> busy_ff && $stable(pair_ff))
    else $error("trigger fall restarted a running conversion");

  c_conversion: cover property (@(posedge CLK) disable iff (!RESETN) $fell(busy_ff));
  c_full_read:  cover property (@(posedge CLK) disable iff (!RESETN) bit_cnt_ff == 5'(LW));
  c_shutdown:   cover property (@(posedge CLK) disable iff (!RESETN) $rose(POWER_DOWN));
  c_fifo_full:  cover property (@(posedge CLK) disable iff (!RESETN) !fifo_in_ready);

endmodule : dsc_ctrl

// ==== pkg/dsc_pkg.sv ====
// Purpose: Shared constants and types of the dual converter sequencing block.
// Assumes: A 10 MHz system clock; all pins but CLK and RESETN enter through two-stage synchronisers.
// Notes:   The synchroniser vector layout is fixed here so every file agrees on it.
package dsc_pkg;

  localparam int DATA_W        = 12;
  localparam int LINE_BITS     = 2 * DATA_W;
  localparam int FIFO_DEPTH    = 32;
  localparam int OSC_DIV       = 4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WAKE_TIME_NS  = 100000;
  localparam int WAKE_CYC      = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_W        = 11;

  // Bit positions of the synchronised pin vector.
  localparam int SYNC_W      = 9;
  localparam int P_COMP_A    = 0;
  localparam int P_COMP_B    = 1;
  localparam int P_REF       = 2;
  localparam int P_SPAN_LO   = 3;
  localparam int P_SPAN_HI   = 4;
  localparam int P_PAIR      = 5;
  localparam int P_SCLK      = 6;
  localparam int P_CS_N      = 7;
  localparam int P_TRIG_N    = 8;

  // Trigger and chip select idle high, everything else low.
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h180;

  localparam logic [DATA_W-1:0]    SAR_RST   = 12'h000;
  localparam logic [DATA_W-1:0]    SAR_MSB   = 12'h800;
  localparam logic [3:0]           IDX_MSB   = 4'hb;
  localparam logic [LINE_BITS-1:0] LINE_RST  = 24'h00_0000;
  localparam logic                 PAIR_RST  = 1'b0;

  localparam logic [1:0] SPAN_BIP10 = 2'h0;
  localparam logic [1:0] SPAN_BIP5  = 2'h1;
  localparam logic [1:0] SPAN_UNI10 = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_STORE,
    ST_DOWN,
    ST_WAKE
  } dsc_state_t;

endpackage : dsc_pkg

// ==== design/dsc_fifo.sv ====
// Purpose: Result FIFO between the converters and the serial read port.
// Assumes: DEPTH is a power of two; read data always come from a register.
// Notes:   Holds DEPTH words in storage plus one in the output register.
`timescale 1ns/1ps
module dsc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             push;
  logic             load;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  // The output register refills from storage whenever storage holds a word and it is empty or being drained.
  assign load      = (cnt_ff != '0) && (!out_valid_ff || out_ready);
  assign out_valid = out_valid_ff;
  assign out_data  = out_data_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (load) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (load) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem[rd_ptr_ff];
    end else if (out_ready) begin
      out_valid_ff <= 1'b0;
    end
  end

endmodule : dsc_fifo

// ==== tb/dsc_host.sv ====
// Purpose: Host side model that starts conversions and reads both result lines.
// Assumes: Result lines change within 400 ns of a serial clock fall.
// Notes:   Timing is free running in ns, so it has no phase tie to CLK.
`timescale 1ns/1ps
module dsc_host (
  output logic      trig_n,
  output logic      cs_n,
  output logic      sclk,
  input  wire logic line_a,
  input  wire logic line_b
);
  // Idle levels: trigger and select high, serial clock parked high.
  initial begin
    trig_n = 1'b1;
    cs_n   = 1'b1;
    sclk   = 1'b1;
  end

  task set_trig(input logic v);
    #37 trig_n = v;
  endtask : set_trig

  task read_frame(output logic [23:0] wa, output logic [23:0] wb);
    cs_n = 1'b0;
    #1630;
    for (int i = 23; i >= 0; i--) begin
      wa[i] = line_a;
      wb[i] = line_b;
      sclk = 1'b0;
      #400;
      sclk = 1'b1;
      #400;
    end
    cs_n = 1'b1;
    #613;
  endtask : read_frame
endmodule : dsc_host

// ==== tb/dual_sar_conversion_control_tb.sv ====
// Purpose: Self-checking bench of the dual converter sequencing block.
// Assumes: Comparators are modelled from one target code per converter.
// Notes:   Expected words are queued at each start and popped at each read while any remain; an empty queue repeats the last word.
`timescale 1ns/1ps
module dual_sar_conversion_control_tb;
  localparam int OSC  = 6;
  localparam int WAKE = 10;
  logic        clk     = 1'b0;
  logic        resetn  = 1'b0;
  logic        pair    = 1'b0;
  logic [1:0]  span    = 2'h0;
  logic        ref_sel = 1'b0;
  logic        cmp_a   = 1'b0;
  logic        cmp_b   = 1'b0;
  logic [11:0] tgt_a   = 12'h000;
  logic [11:0] tgt_b   = 12'h000;
  logic [23:0] wa, wb;
  logic [23:0] last    = 24'h00_0000;
  logic [23:0] expq[$];
  int          seed    = 32'h8e17;
  int          err_total   = 0;
  int          check_count = 0;
  int          cnt;
  wire         trig_n, cs_n, sclk, busy, hold, in_sel, pd, ref_int;
  wire         oe_a, oe_b, o_a, o_b, bip10, bip5, uni10;
  wire [11:0]  dac_a, dac_b;
  wire         line_a = oe_a ? o_a : 1'bz;
  wire         line_b = oe_b ? o_b : 1'bz;

  always #50 clk = ~clk;

  // The held input is at or above the trial code: keep the bit.
  always @(posedge clk) begin
    cmp_a <= (tgt_a >= dac_a);
    cmp_b <= (tgt_b >= dac_b);
  end

  dsc_ctrl #(.OSC_DIV(OSC), .WAKE_CYC(WAKE)) i_dut (
    .CLK(clk), .RESETN(resetn), .CONVERSION_TRIGGER_N(trig_n),
    .CHIP_SELECT_N(cs_n), .SERIAL_CLOCK(sclk), .PAIR_SELECT(pair),
    .SPAN_SELECT_LO(span[0]), .SPAN_SELECT_HI(span[1]),
    .REFERENCE_SOURCE_SELECT(ref_sel), .COMPARE_A(cmp_a), .COMPARE_B(cmp_b),
    .BUSY(busy), .HOLD(hold), .INPUT_SELECT(in_sel), .DAC_CODE_A(dac_a),
    .DAC_CODE_B(dac_b), .SPAN_BIPOLAR_10V(bip10), .SPAN_BIPOLAR_5V(bip5),
    .SPAN_UNIPOLAR_10V(uni10), .REF_INTERNAL(ref_int), .POWER_DOWN(pd),
    .RESULT_LINE_A_O(o_a), .RESULT_LINE_A_OE(oe_a),
    .RESULT_LINE_B_O(o_b), .RESULT_LINE_B_OE(oe_b)
  );

  dsc_host i_host (.trig_n(trig_n), .cs_n(cs_n), .sclk(sclk),
                   .line_a(line_a), .line_b(line_b));

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task chk_bit(input logic got, input logic exp, input string msg);
    chk({23'h0, got}, {23'h0, exp}, msg);
  endtask : chk_bit

  task wait_for(input logic v, input int lim);
    cnt = 0;
    while (busy !== v) begin
      @(negedge clk);
      cnt++;
      if (cnt > lim) begin
        chk_bit(busy, v, "busy wait limit");
        end_of_test;
      end
    end
  endtask : wait_for

  task start(input logic [1:0] sp, input logic keep);
    @(posedge clk);
    tgt_a <= 12'($random(seed));
    tgt_b <= 12'($random(seed));
    pair  <= 1'($random(seed));
    span  <= sp; // span held from here on
    repeat (20) @(posedge clk);
    expq.push_back({tgt_a ^ 12'h800, tgt_b ^ 12'h800});
    i_host.set_trig(1'b0);
    wait_for(1'b1, 20);
    chk_bit(hold, 1'b1, "hold at start");
    repeat (3) @(negedge clk);
    chk({21'h0, uni10, bip5, bip10}, (sp == 2'h3) ? 24'h0 : 24'h1 << sp, "span");
    chk_bit(in_sel, pair, "pair");
    if (!keep)
      i_host.set_trig(1'b1);
  endtask : start

  task finish(input logic down);
    wait_for(1'b0, 12 * OSC + 20);
    chk_bit(hold, 1'b1, "hold before track");
    chk({dac_a, dac_b}, {tgt_a, tgt_b}, "final codes");
    @(negedge clk);
    chk_bit(hold, 1'b0, "hold track");
    chk_bit(pd, down, "power down");
  endtask : finish

  task read_check;
    logic [23:0] e;
    e = (expq.size() > 0) ? expq.pop_front() : last;
    i_host.read_frame(wa, wb);
    chk(wa, e, "line a");
    chk(wb, {e[11:0], e[23:12]}, "line b");
    last = e;
    repeat (6) @(negedge clk);
    chk({22'h0, oe_a, oe_b}, 24'h0, "release");
  endtask : read_check

  initial begin
    ref_sel = 1'($random(seed));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk({19'h0, busy, hold, oe_a, pd, in_sel}, 24'h0, "reset");
    repeat (4) @(negedge clk);
    chk_bit(ref_int, ref_sel, "reference");
    for (int s = 0; s < 4; s++) begin
      start(s[1:0], 1'b0);
      finish(1'b0);
      read_check;
    end
    start(2'h0, 1'b1);
    repeat (30) @(negedge clk);
    i_host.set_trig(1'b1);
    repeat (3) @(negedge clk);
    i_host.set_trig(1'b0);
    finish(1'b1);
    read_check;
    i_host.set_trig(1'b1);
    cnt = 0;
    while (pd === 1'b1 && cnt < 60) begin
      @(negedge clk);
      cnt++;
    end
    chk_bit(cnt >= WAKE && cnt < 60, 1'b1, "wake time");
    for (int k = 0; k < 33; k++) begin
      start(2'h1, 1'b0);
      finish(1'b0);
    end
    start(2'h2, 1'b0);
    repeat (300) @(negedge clk);
    chk_bit(busy, 1'b1, "full buffer stall");
    for (int k = 0; k < 35; k++)
      read_check;
    end_of_test;
  end
endmodule : dual_sar_conversion_control_tb
